// ### inc/gpio_pkg.sv
// Shared constants, types and pin-routing function for the GPIO block
package gpio_pkg;

  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int PORT_COUNT   = 3;
  localparam int PORT_WIDTH   = 8;
  localparam int PIN_COUNT    = 24;
  localparam int MODE_WIDTH   = 4;
  localparam int ADDR_WIDTH   = 8;
  localparam int PORT_SEL_LSB = 5;

  // ********************************************************************
  // Pin mode codes
  // ********************************************************************
  localparam logic [3:0] MODE_ANALOG      = 4'h0;
  localparam logic [3:0] MODE_INPUT_FLOAT = 4'h4;
  localparam logic [3:0] MODE_INPUT_PULL  = 4'h8;
  localparam logic [3:0] MODE_OUT_PUSH    = 4'h1;
  localparam logic [3:0] MODE_OUT_OPEN    = 4'h5;
  localparam logic [3:0] MODE_ALT_PUSH    = 4'h9;
  localparam logic [3:0] MODE_ALT_OPEN    = 4'hd;
  localparam logic [3:0] MODE_RESET       = MODE_INPUT_FLOAT;

  // ********************************************************************
  // Register map (byte offsets within one port, ports 0x20 apart)
  // ********************************************************************
  localparam logic [4:0] OFS_MODE_LO      = 5'h00;
  localparam logic [4:0] OFS_MODE_HI      = 5'h04;
  localparam logic [4:0] OFS_INPUT        = 5'h08;
  localparam logic [4:0] OFS_LATCH        = 5'h0c;
  localparam logic [4:0] OFS_SET          = 5'h10;
  localparam logic [4:0] OFS_CLEAR        = 5'h14;
  localparam logic [4:0] OFS_WAKE         = 5'h18;
  localparam logic [7:0] OFS_TRACE_SELECT = 8'h60;

  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] WAKE_RESET  = 8'h00;
  localparam logic       TRACE_RESET = 1'b0;

  // ********************************************************************
  // Alternate-output routing
  // ********************************************************************
  localparam int TRACE_EN_PIN   = 4;
  localparam int TRACE_DATA_PIN = 5;
  localparam int TIMER_CHANNELS = 4;
  localparam int TIMER_OPT_LSB  = 4;

  typedef enum logic [3:0] {
    reg_none, reg_mode_lo, reg_mode_hi, reg_input, reg_latch,
    reg_set, reg_clear, reg_wake, reg_trace
  } reg_kind_type;

  typedef enum logic {bus_idle, bus_access} bus_state_type;

  // Pin index of a timer-two channel for a given option bit
  function automatic logic [4:0] timer_pin(input logic [1:0] ch,
                                           input logic       sel);
    logic [4:0] pin;
    pin = 5'h00;
    unique case (ch)
      2'd0: pin = sel ? 5'h09 : 5'h00;
      2'd1: pin = sel ? 5'h0a : 5'h03;
      2'd2: pin = sel ? 5'h0b : 5'h01;
      2'd3: pin = sel ? 5'h0c : 5'h02;
    endcase
    return pin;
  endfunction

endpackage

// ### core/pin_sync.sv
// Pin input synchroniser with analog-mode override
`timescale 1ns/1ps
module pin_sync
  import gpio_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic [PIN_COUNT-1:0] pin_in,
  input  wire logic [PIN_COUNT-1:0] analog_mask,
  output logic      [PIN_COUNT-1:0] level_out
);

  logic [PIN_COUNT-1:0] stage_one;
  logic [PIN_COUNT-1:0] stage_two;

  // ********************************************************************
  // Per-pin two-flop synchroniser
  // ********************************************************************
  // Reset to one matches an analog pin so no false wake after reset
  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p++) begin : g_pin
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_one[p] <= 1'b1;
          stage_two[p] <= 1'b1;
          level_out[p] <= 1'b1;
        end else begin
          stage_one[p] <= pin_in[p];
          stage_two[p] <= stage_one[p];
          level_out[p] <= analog_mask[p] | stage_two[p];
        end
      end
    end
  endgenerate

endmodule // pin_sync

// ### core/gpio_port_config_mux.sv
// GPIO port block: pin modes, output latch, wake select, alternate routing
`timescale 1ns/1ps
module gpio_port_config_mux
  import gpio_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  hsel,
  input  wire logic [ADDR_WIDTH-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic      [31:0]           hrdata,
  output logic                       hresp,
  input  wire logic [PIN_COUNT-1:0]  pin_in,
  output logic      [PIN_COUNT-1:0]  pin_out,
  output logic      [PIN_COUNT-1:0]  pin_oe,
  output logic      [PIN_COUNT-1:0]  pull_up_en,
  output logic      [PIN_COUNT-1:0]  pull_down_en,
  output logic      [PIN_COUNT-1:0]  analog_en,
  output logic      [PIN_COUNT-1:0]  pin_level,
  output logic                       wake_event,
  input  wire logic [7:0]            timer_two_pin_option,
  input  wire logic [3:0]            timer_two_output_enables,
  input  wire logic                  timer_two_channel_one_out,
  input  wire logic                  timer_two_channel_two_out,
  input  wire logic                  timer_two_channel_three_out,
  input  wire logic                  timer_two_channel_four_out,
  input  wire logic [PIN_COUNT-1:0]  serial_alt_out,
  input  wire logic [PIN_COUNT-1:0]  serial_alt_used,
  input  wire logic                  packet_trace_enable_out,
  input  wire logic                  packet_trace_data_out,
  input  wire logic                  cpu_trace_bit_two,
  input  wire logic                  cpu_trace_bit_three
);

  // ********************************************************************
  // State
  // ********************************************************************
  logic [PIN_COUNT-1:0][MODE_WIDTH-1:0] pin_mode;
  logic [PIN_COUNT-1:0]                 port_output_latch;
  logic [PIN_COUNT-1:0]                 port_wake_select;
  logic                                 trace_select;
  logic [PIN_COUNT-1:0]                 level_prev;
  bus_state_type                        bus_state;
  logic [ADDR_WIDTH-1:0]                cap_addr;
  logic                                 cap_write;

  logic [PIN_COUNT-1:0]                 analog_vec;
  logic [PIN_COUNT-1:0]                 next_alt;
  logic [PIN_COUNT-1:0]                 next_out;
  logic [PIN_COUNT-1:0]                 next_oe;
  logic [PIN_COUNT-1:0]                 next_up;
  logic [PIN_COUNT-1:0]                 next_down;
  logic [31:0]                          next_rdata;
  logic [TIMER_CHANNELS-1:0]            timer_out;
  logic                                 bus_take;
  logic                                 wr_fire;
  reg_kind_type                         wr_kind;
  int unsigned                          wr_base;

  // Register kind for a byte address; unmapped gives reg_none
  function automatic reg_kind_type reg_decode(input logic [7:0] a);
    reg_kind_type k;
    k = reg_none;
    if (a == OFS_TRACE_SELECT) begin
      k = reg_trace;
    end else if (a[6:5] != 2'd3 && a[7] == 1'b0) begin
      unique case (a[4:0])
        OFS_MODE_LO: k = reg_mode_lo;
        OFS_MODE_HI: k = reg_mode_hi;
        OFS_INPUT:   k = reg_input;
        OFS_LATCH:   k = reg_latch;
        OFS_SET:     k = reg_set;
        OFS_CLEAR:   k = reg_clear;
        OFS_WAKE:    k = reg_wake;
        default:     k = reg_none;
      endcase
    end
    return k;
  endfunction

  // ********************************************************************
  // Input path
  // ********************************************************************
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      analog_vec[p] = (pin_mode[p] == MODE_ANALOG);
    end
  end

  // Level also feeds peripherals and the interrupt pin selectors
  pin_sync u_sync (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .pin_in      (pin_in),
    .analog_mask (analog_vec),
    .level_out   (pin_level)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_prev <= '1;
      wake_event <= 1'b0;
    end else begin
      level_prev <= pin_level;
      wake_event <= |((pin_level ^ level_prev) & port_wake_select);
    end
  end

  // ********************************************************************
  // Alternate output selection
  // ********************************************************************
  assign timer_out = {timer_two_channel_four_out, timer_two_channel_three_out,
                      timer_two_channel_two_out, timer_two_channel_one_out};

  always_comb begin
    next_alt = '0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (serial_alt_used[p]) begin
        next_alt[p] = serial_alt_out[p];
      end
    end
    next_alt[TRACE_EN_PIN] = trace_select ? cpu_trace_bit_two
                                          : packet_trace_enable_out;
    next_alt[TRACE_DATA_PIN] = trace_select ? cpu_trace_bit_three
                                            : packet_trace_data_out;
    // Timer last so it overrides any serial claim on the same pin
    for (int c = 0; c < TIMER_CHANNELS; c++) begin
      if (timer_two_output_enables[c]) begin
        next_alt[timer_pin(c[1:0], timer_two_pin_option[TIMER_OPT_LSB + c])]
          = timer_out[c];
      end
    end
  end

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      next_out[p]  = 1'b0;
      next_oe[p]   = 1'b0;
      next_up[p]   = 1'b0;
      next_down[p] = 1'b0;
      unique case (pin_mode[p])
        MODE_ANALOG:      next_oe[p] = 1'b0;
        MODE_INPUT_FLOAT: next_oe[p] = 1'b0;
        MODE_INPUT_PULL: begin
          next_up[p]   = port_output_latch[p];
          next_down[p] = ~port_output_latch[p];
        end
        MODE_OUT_PUSH: begin
          next_oe[p]  = 1'b1;
          next_out[p] = port_output_latch[p];
        end
        MODE_OUT_OPEN: begin
          next_oe[p] = ~port_output_latch[p];
        end
        MODE_ALT_PUSH: begin
          next_oe[p]  = 1'b1;
          next_out[p] = next_alt[p];
        end
        MODE_ALT_OPEN: begin
          next_oe[p] = ~next_alt[p];
        end
        default:          next_oe[p] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out      <= '0;
      pin_oe       <= '0;
      pull_up_en   <= '0;
      pull_down_en <= '0;
      analog_en    <= '0;
    end else begin
      pin_out      <= next_out;
      pin_oe       <= next_oe;
      pull_up_en   <= next_up;
      pull_down_en <= next_down;
      analog_en    <= analog_vec;
    end
  end

  // ********************************************************************
  // Bus slave: one wait state per transfer
  // ********************************************************************
  // The wait state lets a write land before a following read samples
  assign bus_take = hsel & htrans[1] & hready;
  assign wr_fire  = (bus_state == bus_access) & cap_write;
  assign wr_kind  = reg_decode(cap_addr);
  assign wr_base  = 32'(cap_addr[6:5]) * PORT_WIDTH;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= bus_idle;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      cap_addr  <= '0;
      cap_write <= 1'b0;
    end else begin
      hresp <= 1'b0;
      unique case (bus_state)
        bus_idle: begin
          if (bus_take) begin
            bus_state <= bus_access;
            hreadyout <= 1'b0;
            cap_addr  <= haddr;
            cap_write <= hwrite;
          end
        end
        bus_access: begin
          bus_state <= bus_idle;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (wr_kind)
      reg_mode_lo: next_rdata[15:0] = pin_mode[wr_base +: 4];
      reg_mode_hi: next_rdata[15:0] = pin_mode[wr_base + 4 +: 4];
      reg_input:   next_rdata[7:0] = pin_level[wr_base +: 8];
      reg_latch:   next_rdata[7:0] = port_output_latch[wr_base +: 8];
      reg_wake:    next_rdata[7:0] = port_wake_select[wr_base +: 8];
      reg_trace:   next_rdata[0] = trace_select;
      default:     next_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (bus_state == bus_access && !cap_write) begin
      hrdata <= next_rdata;
    end
  end

  // ********************************************************************
  // Software registers
  // ********************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_mode <= {PIN_COUNT{MODE_RESET}};
    end else if (wr_fire && wr_kind == reg_mode_lo) begin
      pin_mode[wr_base +: 4] <= hwdata[15:0];
    end else if (wr_fire && wr_kind == reg_mode_hi) begin
      pin_mode[wr_base + 4 +: 4] <= hwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_output_latch <= {PORT_COUNT{LATCH_RESET}};
    end else if (wr_fire) begin
      unique case (wr_kind)
        reg_latch: port_output_latch[wr_base +: 8] <= hwdata[7:0];
        reg_set:   port_output_latch[wr_base +: 8] <=
                     port_output_latch[wr_base +: 8] | hwdata[7:0];
        reg_clear: port_output_latch[wr_base +: 8] <=
                     port_output_latch[wr_base +: 8] & ~hwdata[7:0];
        default:   port_output_latch <= port_output_latch;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_wake_select <= {PORT_COUNT{WAKE_RESET}};
      trace_select     <= TRACE_RESET;
    end else if (wr_fire && wr_kind == reg_wake) begin
      port_wake_select[wr_base +: 8] <= hwdata[7:0];
    end else if (wr_fire && wr_kind == reg_trace) begin
      trace_select <= hwdata[0];
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  analog_oe_a:
  assert property ((pin_oe & $past(analog_vec)) == '0)
    else $error("analog pin output enabled");
  analog_level_a:
  assert property (##1 (pin_level | ~$past(analog_vec)) == '1)
    else $error("analog pin input not one");
  push_pull_a:
  assert property (pin_mode[0] == MODE_OUT_PUSH |=>
                   pin_oe[0] && pin_out[0] == $past(port_output_latch[0]))
    else $error("push-pull pin 0 wrong");
  open_drain_a:
  assert property (pin_mode[1] == MODE_OUT_OPEN |=>
                   !pin_out[1] && pin_oe[1] == !$past(port_output_latch[1])
                   && !pull_up_en[1])
    else $error("open-drain pin 1 wrong");
  pull_dir_a:
  assert property (pin_mode[2] == MODE_INPUT_PULL |=>
                   !pin_oe[2] && pull_up_en[2] != pull_down_en[2]
                   && pull_up_en[2] == $past(port_output_latch[2]))
    else $error("pull direction wrong");
  clear_write_a:
  assert property (wr_fire && wr_kind == reg_clear |=>
                   (port_output_latch[$past(wr_base) +: 8]
                    & $past(hwdata[7:0])) == 8'h00)
    else $error("clear strobe left bits set");
  set_write_a:
  assert property (wr_fire && wr_kind == reg_set |=>
                   (port_output_latch[$past(wr_base) +: 8]
                    & $past(hwdata[7:0])) == $past(hwdata[7:0]))
    else $error("set strobe left bits clear");
  timer_win_a:
  assert property (pin_mode[0] == MODE_ALT_PUSH
                   && timer_two_output_enables[0]
                   && !timer_two_pin_option[TIMER_OPT_LSB] |=>
                   pin_out[0] == $past(timer_two_channel_one_out))
    else $error("timer channel one lost pin 0");
  no_periph_a:
  assert property (pin_mode[23] == MODE_ALT_PUSH && !serial_alt_used[23]
                   |=> !pin_out[23] && pin_oe[23])
    else $error("unowned alternate pin not zero");
  wake_cause_a:
  assert property (wake_event |->
                   $past(|((pin_level ^ level_prev) & port_wake_select)))
    else $error("wake without selected change");
  bus_wait_a:
  assert property (bus_state == bus_idle && bus_take |=>
                   !hreadyout ##1 hreadyout)
    else $error("bus answer timing wrong");

  write_cov: cover property (wr_fire && wr_kind == reg_mode_lo);
  read_cov:  cover property (bus_state == bus_access && !cap_write
                             && wr_kind == reg_input);
  wake_cov:  cover property (wake_event);

endmodule // gpio_port_config_mux

// ### test/pin_world.sv
// Far-side model of the 24 pins: outside drivers, pulls, floating lines
`timescale 1ns/1ps
module pin_world
  import gpio_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe,
  input  wire logic [PIN_COUNT-1:0] pull_up_en,
  input  wire logic [PIN_COUNT-1:0] pull_down_en,
  input  wire logic [PIN_COUNT-1:0] ext_en,
  input  wire logic [PIN_COUNT-1:0] ext_level,
  output logic      [PIN_COUNT-1:0] pin_in
);
  logic [PIN_COUNT-1:0] drift;

  // A line nobody holds wanders, so a stale level never looks valid
  initial drift = 24'h000000;
  always @(posedge core_clk) drift <= ~drift;

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_level[i];
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else if (pull_down_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = drift[i];
    end
  end
endmodule // pin_world

// ### test/gpio_port_config_mux_tb.sv
// Self-checking bench for the GPIO port block over AHB-Lite
`timescale 1ns/1ps
module gpio_port_config_mux_tb;
  import gpio_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp, wake_event;
  logic [7:0] haddr, opt;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [23:0] pin_in, pin_out, pin_oe, pu, pd, ana, lvl, ext_en, ext_lv;
  logic [23:0] s_out, s_used;
  logic [3:0] t_en, ch;
  logic [3:0] tr;
  int failures, checks_done, n;

  gpio_port_config_mux i_gpio_port_config_mux (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pu), .pull_down_en(pd), .analog_en(ana), .pin_level(lvl),
    .wake_event(wake_event), .timer_two_pin_option(opt),
    .timer_two_output_enables(t_en), .timer_two_channel_one_out(ch[0]),
    .timer_two_channel_two_out(ch[1]),
    .timer_two_channel_three_out(ch[2]),
    .timer_two_channel_four_out(ch[3]), .serial_alt_out(s_out),
    .serial_alt_used(s_used), .packet_trace_enable_out(tr[0]),
    .packet_trace_data_out(tr[1]), .cpu_trace_bit_two(tr[2]),
    .cpu_trace_bit_three(tr[3]));

  pin_world i_pin_world (
    .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pu), .pull_down_en(pd), .ext_en(ext_en),
    .ext_level(ext_lv), .pin_in(pin_in));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask

  // Entered just after a rising edge; waits on hready, never a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(32'(hresp), 32'h0);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wake_count(input int bit_no);
    ext_lv <= ext_lv ^ (24'h000001 << bit_no);
    n = 0;
    repeat (6) begin
      @(posedge core_clk);
      n += int'(wake_event);
    end
  endtask

  // ********************************************************************
  // Clock and watchdog
  // ********************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    tick(20000);
    failures++;
    print_verdict();
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    {rst_b, hsel, hwrite, haddr, htrans, hwdata} = '0;
    {opt, t_en, ch, tr, s_out, s_used} = '0;
    ext_en = 24'hff0000;
    ext_lv = 24'ha50000;
    failures = 0;
    checks_done = 0;
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    rdchk(8'h00, 32'h00004444);
    rdchk(8'h24, 32'h00004444);
    chk(32'(pin_oe | pu | pd), 32'h0);
    wr(8'h0c, 32'h3c);
    wr(8'h10, 32'h81);
    rdchk(8'h0c, 32'hbd);
    wr(8'h14, 32'h0c);
    rdchk(8'h0c, 32'hb1);
    rdchk(8'h10, 32'h0);
    rdchk(8'h7c, 32'h0);
    wr(8'h00, 32'h1111);
    wr(8'h04, 32'h5555);
    tick(2);
    chk(32'(pin_oe[7:0]), 32'h4f);
    chk(32'(pin_out[7:0]), 32'h01);
    chk(32'(pu[7:0] | pd[7:0]), 32'h0);
    wr(8'h2c, 32'h05);
    wr(8'h20, 32'h8888);
    wr(8'h24, 32'h0);
    tick(5);
    chk(32'({pu[15:8], pd[15:8]}), 32'h050a);
    chk(32'({ana[15:8], pin_oe[15:8]}), 32'hf000);
    chk(32'(lvl[15:12]), 32'hf);
    rdchk(8'h28, 32'hf5);
    rdchk(8'h48, 32'ha5);
    chk(32'(lvl[23:16]), 32'ha5);
    wr(8'h58, 32'h01);
    rdchk(8'h58, 32'h01);
    tick(5);
    wake_count(17);
    chk(32'(n), 32'h0);
    wake_count(16);
    chk(32'(n), 32'h1);
    t_en <= 4'h1;
    ch <= 4'h5;
    s_used <= 24'h00000c;
    s_out <= 24'h00000c;
    tr <= 4'h9;
    wr(8'h00, 32'h9999);
    wr(8'h04, 32'h9999);
    tick(2);
    chk(32'({pin_oe[7:0], pin_out[7:0]}), 32'hff1d);
    t_en <= 4'h3;
    tick(2);
    chk(32'(pin_out[7:0]), 32'h15);
    wr(8'h60, 32'h1);
    tick(2);
    chk(32'(pin_out[7:0]), 32'h25);
    opt <= 8'h10;
    wr(8'h20, 32'h0090);
    tick(2);
    chk(32'({pin_out[9], pin_out[7:0]}), 32'h124);
    wr(8'h04, 32'hdddd);
    tick(2);
    chk(32'({pin_oe[7:4], pin_out[7:4]}), 32'hd0);
    wr(8'h44, 32'h9200);
    tick(2);
    chk(32'({pin_oe[23:20], pin_out[23], ana[23:20]}), 32'h103);
    print_verdict();
  end
endmodule // gpio_port_config_mux_tb
